//--- adc_serial_port_pkg.sv
// Package: constants, mode enumeration and carrier structs for the serial port
package adc_serial_port_pkg;

	// ****************************************
	// Interface modes and strap encodings
	// ****************************************
	typedef enum logic [1:0] {
		MODE_ASYNC_IRQ,
		MODE_SYNC_MASTER,
		MODE_SYNC_SLAVE
	} if_mode_t;

	// Three-level mode pin seen as two comparator bits {float, high}
	localparam logic [1:0] STRAP_HIGH = 2'h1;
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_FLOAT = 2'h2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_SYS_PERIOD_NS = 25;
	// One step of the frame-complete delay field
	localparam int DONE_STEP_NS = 50;
	localparam int DONE_STEP_CYC = (DONE_STEP_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
	localparam int DONE_CNT_W = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_RESULT_READY_STROBE = 1'b1;
	localparam logic RST_DONE_N = 1'b1;
	localparam logic RST_SCLK = 1'b0;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic conv_clock_source_sel;       // Slave mode: 1 = serial clock drives conversion clock
		logic [3:0] clock_config_first;    // Conversion clock half-period, minus one, in sys clocks
		logic [2:0] modulator_clock_divider;
		logic [1:0] frame_complete_delay;
		logic [7:0] rate_mod_periods;      // Modulator half-periods per output result, minus one
	} cfg_t;

	typedef struct packed {
		logic result_overrun_flag;
		logic sync_slip_flag;
		logic filter_reset;
	} status_t;

endpackage

//--- conv_clock_gen.sv
// Conversion clock and modulator clock tick generator
`timescale 1ns/1ps

module conv_clock_gen (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_use_ext_tick,
	input wire logic i_ext_tick,
	input wire logic [3:0] i_internal_conv_clock_div,
	input wire logic [2:0] i_mod_div,
	output logic o_internal_conv_clock_tick,
	output logic o_mod_half_tick
);

	logic [3:0] internal_conv_clock_cnt_q;
	logic [3:0] internal_conv_clock_cnt_d;
	logic [3:0] mod_cnt_q;
	logic [3:0] mod_cnt_d;
	logic internal_conv_clock_tick;
	logic mod_tick;

	// ****************************************
	// Dividers
	// ****************************************
	always_comb begin
		internal_conv_clock_cnt_d = internal_conv_clock_cnt_q;
		internal_conv_clock_tick = 1'b0;
		if (i_use_ext_tick) begin
			internal_conv_clock_cnt_d = 4'h0;
			internal_conv_clock_tick = i_ext_tick;
		end else if (internal_conv_clock_cnt_q >= i_internal_conv_clock_div) begin
			internal_conv_clock_cnt_d = 4'h0;
			internal_conv_clock_tick = 1'b1;
		end else begin
			internal_conv_clock_cnt_d = internal_conv_clock_cnt_q + 4'h1;
		end
		mod_cnt_d = mod_cnt_q;
		mod_tick = 1'b0;
		// Modulator half-period is (divider + 1) conversion clock half-periods
		if (internal_conv_clock_tick) begin
			if (mod_cnt_q >= {1'b0, i_mod_div}) begin
				mod_cnt_d = 4'h0;
				mod_tick = 1'b1;
			end else begin
				mod_cnt_d = mod_cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			internal_conv_clock_cnt_q <= 4'h0;
			mod_cnt_q <= 4'h0;
		end else begin
			internal_conv_clock_cnt_q <= internal_conv_clock_cnt_d;
			mod_cnt_q <= mod_cnt_d;
		end
	end

	assign o_internal_conv_clock_tick = internal_conv_clock_tick;
	assign o_mod_half_tick = mod_tick;

endmodule

//--- adc_serial_port_three_modes.sv
// Serial port of a multichannel converter with three interface modes
`timescale 1ns/1ps

// Overview of operation
// - Asynchronous mode: host holds chip select low for the whole frame.
// - Chip select rising resets the frame, ignores clock and data, releases output.
// - Asynchronous mode: ready strobe falls on each new result regardless of select.
// - Input sampled on falling clock; command applied only after frame completes.
// - Output changes on rising clock; released after the last bit.
// - Ready strobe low for frame; high at select rise or before next result.
// - Result during unfinished frame: strobe high half a modulator period, then low.
// - On overrun keep old shift data, drop the new result, set overrun flag.
// - Ready strobe always driven in asynchronous mode.
// - Host starts frame after strobe falls; select rise returns strobe high.
// - Master mode: device drives clock, strobe and output; host supplies input.
// - Master mode: serial clock runs continuously at the divided conversion clock.
// - Master mode: strobe falling marks new data and starts the frame.
// - Master mode: strobe returns high right after the last bit.
// - Slave mode: select, clock, input and sync are inputs; device drives output.
// - Slave mode: select bounds the frame; its rise resets the interface.
// - Slave mode: source bit picks clock input or serial clock for conversion clock.
// - Modulator clock divided from conversion clock by a three-bit field.
// - Mode caught once after reset from three-level pin: high, low, float.
// - Only clock idle low, launch on rising, capture on falling.
// - Slave mode: misaligned sync pulse sets slip flag and resets the filter.
// - Frame-complete output falls a programmed delay after the last bit.
module adc_serial_port_three_modes #(
	parameter int FRAME_BITS = 32
) (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic [1:0] i_interface_mode_pin,
	input wire adc_serial_port_pkg::cfg_t i_cfg,
	input wire logic i_result_valid,
	input wire logic [FRAME_BITS-1:0] i_result_data,
	input wire logic i_overrun_clr,
	input wire logic i_slip_clr,
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_din,
	input wire logic i_result_ready_strobe,
	output logic o_sclk,
	output logic o_sclk_oe_n,
	output logic o_dout,
	output logic o_dout_oe_n,
	output logic o_result_ready_strobe,
	output logic o_result_ready_strobe_oe_n,
	output logic o_frame_complete_n,
	output logic o_cmd_valid,
	output logic [FRAME_BITS-1:0] o_cmd_word,
	output adc_serial_port_pkg::status_t o_status
);

	localparam int CNT_W = $clog2(FRAME_BITS + 1);
	localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);

	// ****************************************
	// Mode strap
	// ****************************************
	adc_serial_port_pkg::if_mode_t mode_q, mode_d;
	logic strap_done_q, strap_done_d;

	always_comb begin
		mode_d = mode_q;
		strap_done_d = 1'b1;
		if (!strap_done_q) begin
			if (i_interface_mode_pin == adc_serial_port_pkg::STRAP_HIGH) begin
				mode_d = adc_serial_port_pkg::MODE_ASYNC_IRQ;
			end else if (i_interface_mode_pin == adc_serial_port_pkg::STRAP_LOW) begin
				mode_d = adc_serial_port_pkg::MODE_SYNC_MASTER;
			end else begin
				mode_d = adc_serial_port_pkg::MODE_SYNC_SLAVE;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_q <= adc_serial_port_pkg::MODE_ASYNC_IRQ;
			strap_done_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			strap_done_q <= strap_done_d;
		end
	end

	logic is_master;
	logic is_slave;
	assign is_master = strap_done_q && (mode_q == adc_serial_port_pkg::MODE_SYNC_MASTER);
	assign is_slave = strap_done_q && (mode_q == adc_serial_port_pkg::MODE_SYNC_SLAVE);

	// ****************************************
	// Clocks
	// ****************************************
	logic sclk_prev_q;
	logic cs_prev_q;
	logic sync_prev_q;
	logic sclk_int_q, sclk_int_d;
	logic sclk_now;
	logic sclk_rise;
	logic sclk_fall;
	logic internal_conv_clock_tick;
	logic mod_half_tick;

	assign sclk_now = is_master ? sclk_int_q : i_sclk;
	assign sclk_rise = sclk_now && !sclk_prev_q;
	assign sclk_fall = !sclk_now && sclk_prev_q;

	conv_clock_gen u_clk_gen (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_use_ext_tick(is_slave && i_cfg.conv_clock_source_sel),
		.i_ext_tick(sclk_rise || sclk_fall),
		.i_internal_conv_clock_div(i_cfg.clock_config_first),
		.i_mod_div(i_cfg.modulator_clock_divider),
		.o_internal_conv_clock_tick(internal_conv_clock_tick),
		.o_mod_half_tick(mod_half_tick)
	);

	// Free-running in master mode, never gated by frames
	assign sclk_int_d = is_master ? (internal_conv_clock_tick ? !sclk_int_q : sclk_int_q) : 1'b0;

	// ****************************************
	// Frame engine
	// ****************************************
	logic active_q, active_d;
	logic [CNT_W-1:0] bits_q, bits_d;
	logic [FRAME_BITS-1:0] sh_out_q, sh_out_d;
	logic [FRAME_BITS-1:0] sh_in_q, sh_in_d;
	logic dout_q, dout_d;
	logic dout_en_q, dout_en_d;
	logic result_ready_strobe_q, result_ready_strobe_d;
	logic pulse_q, pulse_d;
	logic cmd_valid_q, cmd_valid_d;
	logic [FRAME_BITS-1:0] cmd_q, cmd_d;
	logic overrun_q, overrun_d;
	logic slip_q, slip_d;
	logic filt_rst_q, filt_rst_d;
	logic [7:0] phase_q, phase_d;
	logic done_n_q, done_n_d;
	logic done_run_q, done_run_d;
	logic [adc_serial_port_pkg::DONE_CNT_W-1:0] done_cnt_q, done_cnt_d;
	logic cs_fall;
	logic cs_rise;
	logic sync_fall;
	logic frame_end;
	logic overrun_ev;
	logic armed_q, armed_d;
	logic frame_live;
	logic shift_out_now;

	assign cs_fall = !is_master && cs_prev_q && !i_cs_n;
	assign cs_rise = !is_master && !cs_prev_q && i_cs_n;
	assign sync_fall = is_slave && sync_prev_q && !i_result_ready_strobe;
	assign frame_end = active_q && armed_q && sclk_fall && (bits_q == LAST_BIT) && !cs_rise;
	assign frame_live = active_q && (is_master || !i_cs_n);
	assign shift_out_now = frame_live && sclk_rise;
	assign overrun_ev = i_result_valid && active_q;

	always_comb begin
		active_d = active_q;
		bits_d = bits_q;
		sh_out_d = sh_out_q;
		sh_in_d = sh_in_q;
		dout_d = dout_q;
		dout_en_d = dout_en_q;
		result_ready_strobe_d = result_ready_strobe_q;
		pulse_d = pulse_q;
		cmd_valid_d = 1'b0;
		cmd_d = cmd_q;
		overrun_d = overrun_q && !i_overrun_clr;
		slip_d = slip_q && !i_slip_clr;
		filt_rst_d = 1'b0;
		phase_d = phase_q;
		done_n_d = done_n_q;
		done_run_d = done_run_q;
		done_cnt_d = done_cnt_q;
		armed_d = armed_q;
		// Frame start: select falling, host waits for strobe
		if (cs_fall) begin
			active_d = 1'b1;
			armed_d = 1'b0;
			bits_d = '0;
			dout_en_d = 1'b1;
			done_n_d = 1'b1;
			done_run_d = 1'b0;
		end
		// A free-running clock may fall before the frame's first rise: not a bit
		if (frame_live) begin
			if (sclk_rise) begin
				dout_d = sh_out_q[FRAME_BITS-1];
				sh_out_d = {sh_out_q[FRAME_BITS-2:0], 1'b0};
				armed_d = 1'b1;
			end
			if (sclk_fall && armed_q) begin
				sh_in_d = {sh_in_q[FRAME_BITS-2:0], i_din};
				bits_d = bits_q + 1'b1;
			end
		end
		if (frame_end) begin
			active_d = 1'b0;
			dout_en_d = 1'b0;
			cmd_valid_d = 1'b1;
			cmd_d = {sh_in_q[FRAME_BITS-2:0], i_din};
			done_run_d = 1'b1;
			done_cnt_d = adc_serial_port_pkg::DONE_CNT_W'(({2'h0, i_cfg.frame_complete_delay} + 4'h1)
				* adc_serial_port_pkg::DONE_STEP_CYC);
			if (is_master) begin
				result_ready_strobe_d = 1'b1;
			end
		end
		// Select rise drops any partial frame and releases the output
		if (cs_rise) begin
			active_d = 1'b0;
			bits_d = '0;
			dout_en_d = 1'b0;
			done_n_d = 1'b1;
			done_run_d = 1'b0;
			if (!pulse_q) begin
				result_ready_strobe_d = 1'b1;
			end
		end
		if (done_run_q) begin
			if (done_cnt_q <= 1) begin
				done_run_d = 1'b0;
				done_n_d = 1'b0;
			end else begin
				done_cnt_d = done_cnt_q - 1'b1;
			end
		end
		// Release of the half-period high pulse after an overrun or a superseded result
		if (pulse_q && mod_half_tick) begin
			pulse_d = 1'b0;
			result_ready_strobe_d = 1'b0;
		end
		if (i_result_valid) begin
			if (active_q) begin
				overrun_d = 1'b1;
				pulse_d = !is_slave;
				result_ready_strobe_d = 1'b1;
			end else if (!result_ready_strobe_q && !is_slave) begin
				// Unread result is superseded: strobe goes high just before new data
				sh_out_d = i_result_data;
				pulse_d = 1'b1;
				result_ready_strobe_d = 1'b1;
			end else begin
				sh_out_d = i_result_data;
				result_ready_strobe_d = 1'b0;
				if (is_master) begin
					active_d = 1'b1;
					armed_d = 1'b0;
					bits_d = '0;
					dout_en_d = 1'b1;
					done_n_d = 1'b1;
					done_run_d = 1'b0;
				end
			end
		end
		// Sync alignment check against modulator phase
		if (mod_half_tick) begin
			phase_d = (phase_q >= i_cfg.rate_mod_periods) ? 8'h0 : phase_q + 8'h1;
		end
		if (sync_fall) begin
			if (phase_q != 8'h0) begin
				slip_d = 1'b1;
				filt_rst_d = 1'b1;
			end
			phase_d = 8'h0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
			sync_prev_q <= 1'b1;
			sclk_int_q <= adc_serial_port_pkg::RST_SCLK;
			active_q <= 1'b0;
			bits_q <= '0;
			sh_out_q <= '0;
			sh_in_q <= '0;
			dout_q <= 1'b0;
			dout_en_q <= 1'b0;
			result_ready_strobe_q <= adc_serial_port_pkg::RST_RESULT_READY_STROBE;
			pulse_q <= 1'b0;
			cmd_valid_q <= 1'b0;
			cmd_q <= '0;
			overrun_q <= 1'b0;
			slip_q <= 1'b0;
			filt_rst_q <= 1'b0;
			phase_q <= 8'h0;
			done_n_q <= adc_serial_port_pkg::RST_DONE_N;
			done_run_q <= 1'b0;
			done_cnt_q <= '0;
			armed_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_now;
			cs_prev_q <= i_cs_n;
			sync_prev_q <= i_result_ready_strobe;
			sclk_int_q <= sclk_int_d;
			active_q <= active_d;
			bits_q <= bits_d;
			sh_out_q <= sh_out_d;
			sh_in_q <= sh_in_d;
			dout_q <= dout_d;
			dout_en_q <= dout_en_d;
			result_ready_strobe_q <= result_ready_strobe_d;
			pulse_q <= pulse_d;
			cmd_valid_q <= cmd_valid_d;
			cmd_q <= cmd_d;
			overrun_q <= overrun_d;
			slip_q <= slip_d;
			filt_rst_q <= filt_rst_d;
			phase_q <= phase_d;
			done_n_q <= done_n_d;
			done_run_q <= done_run_d;
			done_cnt_q <= done_cnt_d;
			armed_q <= armed_d;
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	assign o_sclk = sclk_int_q;
	assign o_sclk_oe_n = !is_master;
	assign o_dout = dout_q;
	assign o_dout_oe_n = !dout_en_q;
	assign o_result_ready_strobe = result_ready_strobe_q;
	assign o_result_ready_strobe_oe_n = is_slave;
	assign o_frame_complete_n = done_n_q;
	assign o_cmd_valid = cmd_valid_q;
	assign o_cmd_word = cmd_q;
	assign o_status = '{result_overrun_flag: overrun_q, sync_slip_flag: slip_q,
		filter_reset: filt_rst_q};

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	sequence s_overrun;
		overrun_ev && !is_slave;
	endsequence

	sequence s_pulse_then_low;
		o_result_ready_strobe ##[1:200] !o_result_ready_strobe;
	endsequence

	a_cs_rise_reset: assert property (cs_rise |=> !active_q && o_dout_oe_n && bits_q == '0)
		else $error("select rise did not reset frame");
	a_frame_release: assert property (frame_end |=> o_dout_oe_n && !active_q)
		else $error("output not released after last bit");
	a_cmd_after_frame: assert property (o_cmd_valid |-> $past(frame_end))
		else $error("command applied outside frame end");
	a_overrun_keep: assert property (overrun_ev |=> overrun_q && sh_out_q ==
		($past(shift_out_now) ? ($past(sh_out_q) << 1) : $past(sh_out_q)))
		else $error("overrun not flagged");
	a_overrun_pulse: assert property (s_overrun |=> s_pulse_then_low)
		else $error("overrun pulse missing");
	a_strobe_driven: assert property (strap_done_q
		&& mode_q != adc_serial_port_pkg::MODE_SYNC_SLAVE
		|=> $stable(mode_q) && !o_result_ready_strobe_oe_n)
		else $error("ready strobe tristated");
	a_master_end: assert property (is_master && frame_end && !i_result_valid
		|=> o_result_ready_strobe)
		else $error("master strobe not raised at frame end");
	a_sclk_running: assert property (is_master && internal_conv_clock_tick |=> o_sclk != $past(o_sclk))
		else $error("master clock stalled");
	a_sync_slip: assert property (sync_fall && phase_q != 8'h0 |=> slip_q && filt_rst_q)
		else $error("sync slip not flagged");
	a_new_result: assert property (i_result_valid && !active_q && result_ready_strobe_q && !pulse_q && !is_slave
		|=> !o_result_ready_strobe)
		else $error("strobe did not fall on result");
	a_done_falls: assert property (frame_end ##1 (!cs_rise && !cs_fall && !i_result_valid) [*8]
		|=> !o_frame_complete_n)
		else $error("frame complete not asserted");

endmodule

//--- spi_host_model.sv
// Host controller model that drives the device serial link
`timescale 1ns/1ps

module spi_host_model (
	input wire logic i_clk_sys,
	input wire logic i_dout,
	input wire logic i_dev_sclk,
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_din
);
	// ****************************************
	// Link tasks
	// ****************************************
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0; // Idle low between frames
		o_din = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge i_clk_sys);
		#2;
	endtask

	// Select held low over the whole frame; caller ends it
	task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		rx = 32'h0;
		o_cs_n = 1'b0;
		step(2);
		for (int i = 0; i < nbits; i++) begin
			o_sclk = 1'b1;
			o_din = tx[31-i]; // Launch on rising, device captures on falling
			step(3);
			rx = {rx[30:0], i_dout};
			o_sclk = 1'b0;
			step(3);
		end
	endtask

	task automatic end_frame();
		o_cs_n = 1'b1;
		o_din = ~o_din; // Released line must not keep its last value
		step(1);
	endtask

	// Device owns the clock; bounded waits so a stuck clock cannot hang us
	task automatic master_xfer(input logic [31:0] tx, output logic [31:0] rx, output int hi);
		rx = 32'h0;
		hi = 0;
		// Frame opens on the first rising edge after the strobe falls
		for (int w = 0; w < 40 && i_dev_sclk !== 1'b0; w++) step(1);
		for (int i = 0; i < 32; i++) begin
			for (int w = 0; w < 40 && i_dev_sclk !== 1'b1; w++) step(1);
			o_din = tx[31-i];
			hi = 0;
			for (int w = 0; w < 40 && i_dev_sclk !== 1'b0; w++) begin
				step(1);
				hi++;
			end
			rx = {rx[30:0], i_dout};
		end
	endtask
endmodule

//--- tb_adc_serial_port_three_modes.sv
// Self-checking testbench for the three-mode converter serial port
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module tb_adc_serial_port_three_modes;
	logic clk_sys, arst_n, result_valid, overrun_clr, slip_clr, sync_n;
	logic [1:0] mode_pin;
	adc_serial_port_pkg::cfg_t cfg;
	adc_serial_port_pkg::status_t status;
	logic [31:0] result_data, rx, cmd_word, cmd_word_seen;
	logic cs_n, sclk, din, dev_sclk, sclk_oe_n, dout, dout_oe_n;
	logic result_ready_strobe, result_ready_strobe_oe_n, done_n, cmd_valid, done_prev;
	int fails = 0, samples_checked = 0, cyc = 0, cmd_cnt = 0, cmd_cyc = 0, done_cyc = 0;
	int flt_cnt = 0, hi = 0, ovr_hi = 0;

	// ****************************************
	// Design, host and monitors
	// ****************************************
	adc_serial_port_three_modes #(.FRAME_BITS(32)) u_dut (
		.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_interface_mode_pin(mode_pin),
		.i_cfg(cfg), .i_result_valid(result_valid), .i_result_data(result_data),
		.i_overrun_clr(overrun_clr), .i_slip_clr(slip_clr), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_din(din), .i_result_ready_strobe(sync_n),
		.o_sclk(dev_sclk), .o_sclk_oe_n(sclk_oe_n), .o_dout(dout), .o_dout_oe_n(dout_oe_n),
		.o_result_ready_strobe(result_ready_strobe), .o_result_ready_strobe_oe_n(result_ready_strobe_oe_n),
		.o_frame_complete_n(done_n), .o_cmd_valid(cmd_valid), .o_cmd_word(cmd_word),
		.o_status(status)
	);

	spi_host_model u_host (
		.i_clk_sys(clk_sys), .i_dout(dout), .i_dev_sclk(dev_sclk),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din)
	);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		done_prev <= done_n;
		if (cmd_valid === 1'b1) begin
			cmd_cnt <= cmd_cnt + 1;
			cmd_cyc <= cyc;
			cmd_word_seen <= cmd_word;
		end
		if (done_n === 1'b0 && done_prev === 1'b1) done_cyc <= cyc;
		if (status.filter_reset === 1'b1) flt_cnt <= flt_cnt + 1;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask

	task automatic do_reset(input logic [1:0] strap);
		arst_n = 1'b0;
		mode_pin = strap;
		step(6);
		arst_n = 1'b1;
		step(2);
	endtask

	task automatic post_result(input logic [31:0] d);
		result_data = d;
		result_valid = 1'b1;
		step(1);
		result_valid = 1'b0;
	endtask

	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Five frames of at most about two hundred cycles each, with ample margin
	initial begin
		#(6000 * 25);
		fails++;
		results();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{result_valid, overrun_clr, slip_clr, sync_n} = 4'h1;
		result_data = 32'h0;
		cfg = 18'h0; // Conversion clock from the internal divider, so host clock may pause
		cfg.clock_config_first = 4'h1;
		cfg.frame_complete_delay = 2'h2;
		cfg.rate_mod_periods = 8'h0f;
		do_reset(adc_serial_port_pkg::STRAP_HIGH);
		`CHK(result_ready_strobe, 1'b1)
		`CHK(result_ready_strobe_oe_n, 1'b0)
		`CHK({sclk_oe_n, dout_oe_n, done_n, status}, 6'h38)
		post_result(32'ha5c3_0f96);
		step(1);
		`CHK(result_ready_strobe, 1'b0)
		`CHK(dout_oe_n, 1'b1)
		u_host.xfer(32'h1234_abcd, 32, rx);
		`CHK(rx, 32'ha5c3_0f96)
		`CHK(dout_oe_n, 1'b1)
		`CHK(result_ready_strobe, 1'b0)
		step(10);
		`CHK(cmd_cnt, 1)
		`CHK(cmd_word_seen, 32'h1234_abcd)
		`CHK(done_cyc - cmd_cyc, 3 * adc_serial_port_pkg::DONE_STEP_CYC)
		u_host.end_frame();
		step(1);
		`CHK({result_ready_strobe, done_n}, 2'h3)
		// Aborted frame leaves no command behind
		u_host.xfer(32'hffff_0000, 8, rx);
		`CHK(dout_oe_n, 1'b0)
		u_host.end_frame();
		step(1);
		`CHK(dout_oe_n, 1'b1)
		step(4);
		`CHK(cmd_cnt, 1)
		// Result lands while the previous one is still shifting
		post_result(32'h5a5a_3c3c);
		step(2);
		fork
			u_host.xfer(32'h0, 32, rx);
			begin
				step(40);
				post_result(32'hdead_0001);
				repeat (6) begin
					if (result_ready_strobe === 1'b1) ovr_hi++;
					step(1);
				end
				`CHK(result_ready_strobe, 1'b0)
				`CHK(status.result_overrun_flag, 1'b1)
			end
		join
		`CHK(ovr_hi inside {[1:2]}, 1'b1)
		`CHK(rx, 32'h5a5a_3c3c)
		u_host.end_frame();
		overrun_clr = 1'b1;
		step(1);
		overrun_clr = 1'b0;
		step(1);
		`CHK(status.result_overrun_flag, 1'b0)
		// Device-clocked mode
		do_reset(adc_serial_port_pkg::STRAP_LOW);
		`CHK({sclk_oe_n, result_ready_strobe_oe_n}, 2'h0)
		post_result(32'h8001_7ffe);
		for (int w = 0; w < 8 && result_ready_strobe !== 1'b0; w++) step(1);
		`CHK(result_ready_strobe, 1'b0)
		u_host.master_xfer(32'hc0de_0042, rx, hi);
		`CHK(rx, 32'h8001_7ffe)
		`CHK(hi, 2)
		step(2);
		`CHK(result_ready_strobe, 1'b1)
		step(4);
		`CHK(cmd_word_seen, 32'hc0de_0042)
		// Host-clocked mode with sync input
		do_reset(adc_serial_port_pkg::STRAP_FLOAT);
		`CHK({result_ready_strobe_oe_n, sclk_oe_n}, 2'h3)
		sync_n = 1'b0; // Sync driven apart from select
		step(1);
		sync_n = 1'b1;
		step(4);
		sync_n = 1'b0;
		step(3);
		`CHK(status.sync_slip_flag, 1'b1)
		`CHK(flt_cnt > 0, 1'b1)
		slip_clr = 1'b1;
		step(1);
		slip_clr = 1'b0;
		step(1);
		`CHK(status.sync_slip_flag, 1'b0)
		post_result(32'h0f0f_7001);
		step(2);
		u_host.xfer(32'h0000_0011, 32, rx);
		`CHK(rx, 32'h0f0f_7001)
		u_host.end_frame();
		results();
	end
endmodule
